//--- include/mss_pkg.sv
// Purpose: shared constants for the module safety supervisor
// Assumes: 50 MHz clk_sys, classic wishbone register access
// Notes: indicator colours are two-bit codes
package mss_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int OUT_WD_DEFAULT_MS = 2500;
    // register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SYS_INTERVAL = 8'h08;
    localparam logic [7:0] ADDR_IN_INTERVAL = 8'h0c;
    localparam logic [7:0] ADDR_OUT_INTERVAL = 8'h10;
    localparam logic [7:0] ADDR_EXPECT_TYPE = 8'h14;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h18;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h1c;
    localparam logic [7:0] ADDR_INT_CLEAR = 8'h20;
    localparam logic [7:0] ADDR_ACTUAL_TYPE = 8'h24;
    // ctrl bits
    localparam int CTRL_CRIT_FAULT = 0;
    localparam int CTRL_FW_FAIL = 1;
    localparam int CTRL_FAULT = 2;
    localparam int CTRL_REMOTE_RESET = 3;
    // interrupt event bits
    localparam int EV_RECOVERY = 0;
    localparam int EV_UNLOCK = 1;
    localparam int EV_IN_TIMEOUT = 2;
    localparam int EV_OUT_TIMEOUT = 3;
    localparam int EV_MISMATCH = 4;
    localparam int EV_W = 5;
    // led colour codes
    localparam logic [1:0] LED_OFF = 2'h0;
    localparam logic [1:0] LED_GREEN = 2'h1;
    localparam logic [1:0] LED_RED = 2'h2;
    localparam logic [1:0] LED_AMBER = 2'h3;
    localparam int BOOT_WINDOW_MS = 1;
    typedef enum logic [1:0] {
        PM_BOOT = 2'b00,
        PM_RUN = 2'b01,
        PM_HALT = 2'b11,
        PM_RECOVERY = 2'b10
    } mss_pmode_e;
    typedef enum logic [1:0] {
        IO_OFF = 2'b00,
        IO_EDUCATE = 2'b01,
        IO_RUN = 2'b11,
        IO_SAFE = 2'b10
    } mss_iomode_e;
endpackage

//--- hdl/module_safety_supervisor.sv
// Purpose: processor and i/o module safety supervision with wishbone registers
// Assumes: all inputs synchronous to clk_sys; one input and one output module watched
// Notes: intervals are in ms; zero module interval means use system interval
//
// Overview of operation
// - critical firmware failure forces recovery mode automatically
// - fault reset button or remote reset just after boot enters recovery
// - recovery: ready/run/force/spare amber, health green, red on fault
// - recovery mode disables i/o communication and application execution
// - processor fault turns system health and module health red
// - single critical fault alone moves processor to recovery
// - processor unlock while operational flags fault and halts module
// - i/o module operational only while its switch is locked
// - first i/o module locked starts education with no command
// - i/o unlock: health green, ready off, run red, channels off
// - each i/o module interval settable apart from system interval
// - zero module interval falls back to processor system interval
// - input update missing past interval puts module safe, reports safe values
// - output module shuts down after interval with no update, default 2500 ms
// - configured module type compared against the type actually present
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
module module_safety_supervisor #(
    parameter int TYPE_W = 4,
    parameter int CHAN_N = 16,
    parameter int MS_DIV = mss_pkg::MS_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic procLocked,
    input wire logic faultResetButton,
    input wire logic ioLocked,
    input wire logic [TYPE_W-1:0] ioTypePresent,
    input wire logic inUpdate,
    input wire logic outUpdate,
    input wire logic [CHAN_N-1:0] chanCmd,
    output logic ioCommEnable,
    output logic appRunEnable,
    output logic [1:0] ledSysHealth,
    output logic [1:0] ledHealth,
    output logic [1:0] ledReady,
    output logic [1:0] ledRun,
    output logic [1:0] ledForce,
    output logic [1:0] ledSpare,
    output logic [1:0] ledIoHealth,
    output logic [1:0] ledIoReady,
    output logic [1:0] ledIoRun,
    output logic [CHAN_N-1:0] chanOut,
    output logic inSafe,
    output logic outShutdown,
    output logic irq
);
    initial begin
        if (TYPE_W < 1 || TYPE_W > 16 || CHAN_N < 1 || CHAN_N > 32 || MS_DIV < 2) begin
            $error("module_safety_supervisor: unsupported parameters");
        end
    end

    localparam int DIV_W = $clog2(MS_DIV);

    mss_pkg::mss_pmode_e pMode_r;
    mss_pkg::mss_iomode_e ioMode_r;
    logic [3:0] ctrl_r;
    logic [15:0] sysInterval_r, inInterval_r, outInterval_r;
    logic [TYPE_W-1:0] expectType_r;
    logic [mss_pkg::EV_W-1:0] intStatus_r, intEnable_r, events;
    logic [DIV_W-1:0] div_r;
    logic msTick;
    logic [15:0] inCnt_r, outCnt_r, bootCnt_r;
    logic [15:0] inLimit, outLimit;
    logic faultSeen_r, procFault;
    logic wbWrite, wbRead;

    // a write lands on the edge where the master sees ack, never on the edge it is taken
    assign wbWrite = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign wbRead = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    // millisecond enable
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= '0;
        end else if (div_r == DIV_W'(MS_DIV - 1)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end
    assign msTick = (div_r == DIV_W'(MS_DIV - 1));

    // register writes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= '0;
            sysInterval_r <= 16'(mss_pkg::OUT_WD_DEFAULT_MS);
            inInterval_r <= '0;
            outInterval_r <= '0;
            expectType_r <= '0;
            intEnable_r <= '0;
        end else if (wbWrite && wb_sel_i[0]) begin
            case (wb_adr_i)
                mss_pkg::ADDR_CTRL: ctrl_r <= wb_dat_i[3:0];
                mss_pkg::ADDR_SYS_INTERVAL: sysInterval_r <= wb_dat_i[15:0];
                mss_pkg::ADDR_IN_INTERVAL: inInterval_r <= wb_dat_i[15:0];
                mss_pkg::ADDR_OUT_INTERVAL: outInterval_r <= wb_dat_i[15:0];
                mss_pkg::ADDR_EXPECT_TYPE: expectType_r <= wb_dat_i[TYPE_W-1:0];
                mss_pkg::ADDR_INT_ENABLE: intEnable_r <= wb_dat_i[mss_pkg::EV_W-1:0];
                default: ;
            endcase
        end
    end

    // read path and ack; one wait cycle per access
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wbRead) begin
                case (wb_adr_i)
                    mss_pkg::ADDR_CTRL: wb_dat_o <= 32'(ctrl_r);
                    mss_pkg::ADDR_STATUS: wb_dat_o <= 32'({ioMode_r, pMode_r, outShutdown, inSafe});
                    mss_pkg::ADDR_SYS_INTERVAL: wb_dat_o <= 32'(sysInterval_r);
                    mss_pkg::ADDR_IN_INTERVAL: wb_dat_o <= 32'(inInterval_r);
                    mss_pkg::ADDR_OUT_INTERVAL: wb_dat_o <= 32'(outInterval_r);
                    mss_pkg::ADDR_EXPECT_TYPE: wb_dat_o <= 32'(expectType_r);
                    mss_pkg::ADDR_INT_STATUS: wb_dat_o <= 32'(intStatus_r);
                    mss_pkg::ADDR_INT_ENABLE: wb_dat_o <= 32'(intEnable_r);
                    mss_pkg::ADDR_ACTUAL_TYPE: wb_dat_o <= 32'(ioTypePresent);
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

    assign procFault = ctrl_r[mss_pkg::CTRL_FAULT] || ctrl_r[mss_pkg::CTRL_CRIT_FAULT];

    // boot window counter for the manual recovery request
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bootCnt_r <= '0;
        end else if (pMode_r == mss_pkg::PM_BOOT && msTick) begin
            bootCnt_r <= bootCnt_r + 1'b1;
        end
    end

    // processor mode; recovery is only left by reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pMode_r <= mss_pkg::PM_BOOT;
        end else begin
            case (pMode_r)
                mss_pkg::PM_BOOT: begin
                    if (ctrl_r[mss_pkg::CTRL_FW_FAIL] || ctrl_r[mss_pkg::CTRL_CRIT_FAULT]) begin
                        pMode_r <= mss_pkg::PM_RECOVERY;
                    end else if (faultResetButton || ctrl_r[mss_pkg::CTRL_REMOTE_RESET]) begin
                        pMode_r <= mss_pkg::PM_RECOVERY;
                    end else if (bootCnt_r >= 16'(mss_pkg::BOOT_WINDOW_MS) && procLocked) begin
                        pMode_r <= mss_pkg::PM_RUN;
                    end
                end
                mss_pkg::PM_RUN: begin
                    if (ctrl_r[mss_pkg::CTRL_FW_FAIL] || ctrl_r[mss_pkg::CTRL_CRIT_FAULT]) begin
                        pMode_r <= mss_pkg::PM_RECOVERY;
                    end else if (!procLocked) begin
                        pMode_r <= mss_pkg::PM_HALT;
                    end
                end
                mss_pkg::PM_HALT: begin
                    if (ctrl_r[mss_pkg::CTRL_FW_FAIL] || ctrl_r[mss_pkg::CTRL_CRIT_FAULT]) begin
                        pMode_r <= mss_pkg::PM_RECOVERY;
                    end
                end
                mss_pkg::PM_RECOVERY: pMode_r <= mss_pkg::PM_RECOVERY;
                default: pMode_r <= mss_pkg::PM_HALT;
            endcase
        end
    end

    // latched fault view: unlock fault stays until reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            faultSeen_r <= 1'b0;
        end else if (pMode_r == mss_pkg::PM_HALT) begin
            faultSeen_r <= 1'b1;
        end
    end

    // processor outputs and indicators
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ioCommEnable <= 1'b0;
            appRunEnable <= 1'b0;
            ledSysHealth <= mss_pkg::LED_OFF;
            ledHealth <= mss_pkg::LED_OFF;
            ledReady <= mss_pkg::LED_OFF;
            ledRun <= mss_pkg::LED_OFF;
            ledForce <= mss_pkg::LED_OFF;
            ledSpare <= mss_pkg::LED_OFF;
        end else begin
            ioCommEnable <= (pMode_r == mss_pkg::PM_RUN);
            appRunEnable <= (pMode_r == mss_pkg::PM_RUN);
            if (pMode_r == mss_pkg::PM_RECOVERY) begin
                ledReady <= mss_pkg::LED_AMBER;
                ledRun <= mss_pkg::LED_AMBER;
                ledForce <= mss_pkg::LED_AMBER;
                ledSpare <= mss_pkg::LED_AMBER;
                ledSysHealth <= ctrl_r[mss_pkg::CTRL_FAULT] ? mss_pkg::LED_RED : mss_pkg::LED_GREEN;
                ledHealth <= ctrl_r[mss_pkg::CTRL_FAULT] ? mss_pkg::LED_RED : mss_pkg::LED_GREEN;
            end else begin
                ledReady <= (pMode_r == mss_pkg::PM_RUN) ? mss_pkg::LED_GREEN : mss_pkg::LED_OFF;
                ledRun <= (pMode_r == mss_pkg::PM_RUN) ? mss_pkg::LED_GREEN : mss_pkg::LED_OFF;
                ledForce <= mss_pkg::LED_OFF;
                ledSpare <= mss_pkg::LED_OFF;
                ledSysHealth <= (procFault || faultSeen_r) ? mss_pkg::LED_RED : mss_pkg::LED_GREEN;
                ledHealth <= (procFault || faultSeen_r) ? mss_pkg::LED_RED : mss_pkg::LED_GREEN;
            end
        end
    end

    // i/o module mode: education starts on lock, unlock switches off
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ioMode_r <= mss_pkg::IO_OFF;
        end else if (!ioLocked) begin
            ioMode_r <= mss_pkg::IO_OFF;
        end else begin
            case (ioMode_r)
                mss_pkg::IO_OFF: ioMode_r <= mss_pkg::IO_EDUCATE;
                mss_pkg::IO_EDUCATE: begin
                    if (ioTypePresent == expectType_r && pMode_r == mss_pkg::PM_RUN) begin
                        ioMode_r <= mss_pkg::IO_RUN;
                    end
                end
                mss_pkg::IO_RUN: begin
                    if (ioTypePresent != expectType_r) begin
                        ioMode_r <= mss_pkg::IO_SAFE;
                    end
                end
                mss_pkg::IO_SAFE: ioMode_r <= mss_pkg::IO_SAFE;
                default: ioMode_r <= mss_pkg::IO_OFF;
            endcase
        end
    end

    // module interval or the system fallback
    assign inLimit = (inInterval_r == '0) ? sysInterval_r : inInterval_r;
    assign outLimit = (outInterval_r == '0) ? sysInterval_r : outInterval_r;

    // input watchdog; updates only count while i/o traffic is allowed
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            inCnt_r <= '0;
            inSafe <= 1'b1;
        end else if (ioMode_r != mss_pkg::IO_RUN || !ioCommEnable) begin
            inCnt_r <= '0;
            inSafe <= 1'b1;
        end else if (inUpdate) begin
            inCnt_r <= '0;
            inSafe <= 1'b0;
        end else if (msTick && !inSafe) begin
            if (inCnt_r + 16'h0001 >= inLimit) begin
                inSafe <= 1'b1;
            end
            inCnt_r <= inCnt_r + 16'h0001;
        end
    end

    // output watchdog; shutdown holds until a fresh update
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            outCnt_r <= '0;
            outShutdown <= 1'b1;
        end else if (ioMode_r != mss_pkg::IO_RUN || !ioCommEnable) begin
            outCnt_r <= '0;
            outShutdown <= 1'b1;
        end else if (outUpdate) begin
            outCnt_r <= '0;
            outShutdown <= 1'b0;
        end else if (msTick && !outShutdown) begin
            if (outCnt_r + 16'h0001 >= outLimit) begin
                outShutdown <= 1'b1;
            end
            outCnt_r <= outCnt_r + 16'h0001;
        end
    end

    // i/o indicators and channels; safe values report as zero
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ledIoHealth <= mss_pkg::LED_OFF;
            ledIoReady <= mss_pkg::LED_OFF;
            ledIoRun <= mss_pkg::LED_OFF;
            chanOut <= '0;
        end else begin
            ledIoHealth <= (ioMode_r == mss_pkg::IO_SAFE) ? mss_pkg::LED_RED : mss_pkg::LED_GREEN;
            ledIoReady <= (ioMode_r == mss_pkg::IO_RUN && !outShutdown) ? mss_pkg::LED_GREEN
                        : (ioMode_r == mss_pkg::IO_RUN) ? mss_pkg::LED_RED : mss_pkg::LED_OFF;
            ledIoRun <= (ioMode_r == mss_pkg::IO_RUN && !outShutdown) ? mss_pkg::LED_GREEN
                      : mss_pkg::LED_RED;
            chanOut <= (ioMode_r == mss_pkg::IO_RUN && !outShutdown) ? chanCmd : '0;
        end
    end

    // sticky events; set wins over clear
    assign events = {
        (ioMode_r == mss_pkg::IO_RUN && ioTypePresent != expectType_r),
        (ioMode_r == mss_pkg::IO_RUN && outShutdown),
        (ioMode_r == mss_pkg::IO_RUN && inSafe && inCnt_r != '0),
        (pMode_r == mss_pkg::PM_RUN && !procLocked),
        (pMode_r != mss_pkg::PM_RECOVERY && (ctrl_r[mss_pkg::CTRL_FW_FAIL] || ctrl_r[mss_pkg::CTRL_CRIT_FAULT]))
    };
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            intStatus_r <= '0;
            irq <= 1'b0;
        end else begin
            if (wbWrite && wb_sel_i[0] && wb_adr_i == mss_pkg::ADDR_INT_CLEAR) begin
                intStatus_r <= (intStatus_r & ~wb_dat_i[mss_pkg::EV_W-1:0]) | events;
            end else begin
                intStatus_r <= intStatus_r | events;
            end
            irq <= |(intStatus_r & intEnable_r);
        end
    end

    property p_recovery_on_crit;
        @(posedge clk_sys) disable iff (!rst_b)
        (ctrl_r[mss_pkg::CTRL_CRIT_FAULT] && pMode_r != mss_pkg::PM_RECOVERY) |=> pMode_r == mss_pkg::PM_RECOVERY;
    endproperty
    a_recovery_on_crit: assert property (p_recovery_on_crit) else $error("critical fault missed recovery");

    property p_recovery_on_fw;
        @(posedge clk_sys) disable iff (!rst_b)
        (ctrl_r[mss_pkg::CTRL_FW_FAIL] && pMode_r != mss_pkg::PM_RECOVERY) |=> pMode_r == mss_pkg::PM_RECOVERY;
    endproperty
    a_recovery_on_fw: assert property (p_recovery_on_fw) else $error("firmware failure missed recovery");

    property p_manual_recovery;
        @(posedge clk_sys) disable iff (!rst_b)
        (pMode_r == mss_pkg::PM_BOOT && faultResetButton) |=> pMode_r == mss_pkg::PM_RECOVERY;
    endproperty
    a_manual_recovery: assert property (p_manual_recovery) else $error("button did not enter recovery");

    property p_recovery_leds;
        @(posedge clk_sys) disable iff (!rst_b)
        (pMode_r == mss_pkg::PM_RECOVERY && !ctrl_r[mss_pkg::CTRL_FAULT]) |=>
            ledReady == mss_pkg::LED_AMBER && ledSpare == mss_pkg::LED_AMBER && ledHealth == mss_pkg::LED_GREEN;
    endproperty
    a_recovery_leds: assert property (p_recovery_leds) else $error("recovery indicators wrong");

    property p_recovery_no_io;
        @(posedge clk_sys) disable iff (!rst_b)
        $past(pMode_r) == mss_pkg::PM_RECOVERY |-> !ioCommEnable && !appRunEnable;
    endproperty
    a_recovery_no_io: assert property (p_recovery_no_io) else $error("i/o active in recovery");

    property p_fault_red;
        @(posedge clk_sys) disable iff (!rst_b)
        (ctrl_r[mss_pkg::CTRL_FAULT] && pMode_r != mss_pkg::PM_RECOVERY) |=> ledSysHealth == mss_pkg::LED_RED;
    endproperty
    a_fault_red: assert property (p_fault_red) else $error("fault not shown red");

    property p_unlock_halt;
        @(posedge clk_sys) disable iff (!rst_b)
        (pMode_r == mss_pkg::PM_RUN && !procLocked && !procFault && !ctrl_r[mss_pkg::CTRL_FW_FAIL])
            |=> pMode_r == mss_pkg::PM_HALT ##2 ledHealth == mss_pkg::LED_RED;
    endproperty
    a_unlock_halt: assert property (p_unlock_halt) else $error("unlock did not halt");

    property p_io_unlock;
        @(posedge clk_sys) disable iff (!rst_b)
        !ioLocked |=> ##1 chanOut == '0 && ledIoRun == mss_pkg::LED_RED && ledIoReady == mss_pkg::LED_OFF;
    endproperty
    a_io_unlock: assert property (p_io_unlock) else $error("unlock indications wrong");

    property p_out_restart;
        @(posedge clk_sys) disable iff (!rst_b)
        (outUpdate && ioMode_r == mss_pkg::IO_RUN && ioCommEnable) |=> outCnt_r == '0 && !outShutdown;
    endproperty
    a_out_restart: assert property (p_out_restart) else $error("watchdog did not restart");

    c_recovery: cover property (@(posedge clk_sys) disable iff (!rst_b) pMode_r == mss_pkg::PM_RECOVERY);
    c_out_timeout: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(outShutdown));
    c_in_timeout: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(inSafe));
    c_halt: cover property (@(posedge clk_sys) disable iff (!rst_b) pMode_r == mss_pkg::PM_HALT);
endmodule

//--- test/mss_proc_model.sv
// Purpose: processor side model issuing periodic input and output updates
// Assumes: one-cycle pulses every third cycle while go is high
// Notes: go low models a stalled application cycle
`timescale 1ns/1ns
module mss_proc_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic go,
    output logic inUpdate,
    output logic outUpdate
);
    logic [1:0] phase_r;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
        end
    end
    // one cadence for both so their watchdogs restart together
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            inUpdate <= 1'b0;
            outUpdate <= 1'b0;
        end else begin
            inUpdate <= go && phase_r == 2'h0;
            outUpdate <= go && phase_r == 2'h0;
        end
    end
endmodule

//--- test/tb.sv
// Purpose: self-checking bench for the module safety supervisor
// Assumes: MS_DIV shortened to 8, so one ms is eight cycles
// Notes: read results are queued by the driver and checked by a monitor
`timescale 1ns/1ns
module tb;
    logic clk_sys = 0, rst_b = 0, wbCyc = 0, wbStb = 0, wbWe = 0, ack, irq, go = 0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0, ioType = 4'h5;
    logic [31:0] wbDatI = 32'h0, wbDatO;
    logic procLocked = 1, button = 0, ioLocked = 1, inUpd, outUpd, ioComm, appRun, inSafe, outShut;
    logic [15:0] chanCmd = 16'h0, chanOut;
    logic [1:0] lSys, lHl, lRdy, lRun, lFrc, lSpr, lIoH, lIoRdy, lIoRun;
    logic [31:0] expQ[$];
    int fails = 0, check_count = 0, cycles = 0, seed = 47;
    module_safety_supervisor #(.MS_DIV(8)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(ack), .procLocked(procLocked), .faultResetButton(button),
        .ioLocked(ioLocked), .ioTypePresent(ioType), .inUpdate(inUpd), .outUpdate(outUpd),
        .chanCmd(chanCmd), .ioCommEnable(ioComm), .appRunEnable(appRun), .ledSysHealth(lSys),
        .ledHealth(lHl), .ledReady(lRdy), .ledRun(lRun), .ledForce(lFrc), .ledSpare(lSpr),
        .ledIoHealth(lIoH), .ledIoReady(lIoRdy), .ledIoRun(lIoRun), .chanOut(chanOut),
        .inSafe(inSafe), .outShutdown(outShut), .irq(irq));
    mss_proc_model partner (.clk_sys(clk_sys), .rst_b(rst_b), .go(go), .inUpdate(inUpd), .outUpdate(outUpd));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    task ck(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        if (fails == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wbCyc <= 1;
        wbStb <= 1;
        wbWe <= we;
        wbAdr <= a;
        wbDatI <= d;
        wbSel <= 4'hf;
        do @(posedge clk_sys); while (ack !== 1'b1);
        wbCyc <= 0;
        wbStb <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        expQ.push_back(exp);
        wb(0, a, 32'h0);
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task do_reset;
        @(posedge clk_sys);
        rst_b <= 0;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1;
    endtask
    // read data is compared only where the slave acknowledges a read
    always @(posedge clk_sys) begin
        if (ack === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) begin
            ck(wbDatO, expQ.pop_front());
        end
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        do_reset();
        wb(1, mss_pkg::ADDR_EXPECT_TYPE, 32'h5);
        rd(mss_pkg::ADDR_SYS_INTERVAL, 32'h9c4);
        rd(8'h3c, 32'h0);
        wb(1, mss_pkg::ADDR_IN_INTERVAL, 32'h2);
        wb(1, mss_pkg::ADDR_SYS_INTERVAL, 32'h6);
        wb(1, mss_pkg::ADDR_OUT_INTERVAL, 32'h0);
        chanCmd <= 16'($random(seed));
        go <= 1;
        wt(80);
        rd(mss_pkg::ADDR_STATUS, 32'h34);
        ck({ioComm, appRun, outShut, inSafe}, 4'hc);
        ck(chanOut, chanCmd);
        wb(1, mss_pkg::ADDR_INT_CLEAR, 32'h1f);
        wb(1, mss_pkg::ADDR_INT_ENABLE, 32'h0c);
        go <= 0;
        wt(28);
        ck({inSafe, outShut}, 2'h2);
        wt(34);
        ck({outShut, irq}, 2'h3);
        ck(chanOut, 16'h0);
        rd(mss_pkg::ADDR_INT_STATUS, 32'h0c);
        go <= 1;
        wt(10);
        wb(1, mss_pkg::ADDR_INT_CLEAR, 32'h0c);
        rd(mss_pkg::ADDR_INT_STATUS, 32'h0);
        wt(2);
        ck({irq, inSafe, outShut}, 3'h0);
        ioType <= 4'h6;
        wt(4);
        rd(mss_pkg::ADDR_STATUS, 32'h27);
        rd(mss_pkg::ADDR_INT_STATUS, 32'h10);
        rd(mss_pkg::ADDR_ACTUAL_TYPE, 32'h6);
        wb(1, mss_pkg::ADDR_CTRL, 32'h4);
        wt(2);
        ck({lSys, lHl}, {mss_pkg::LED_RED, mss_pkg::LED_RED});
        // fault cleared first, so the unlock alone must turn health red
        wb(1, mss_pkg::ADDR_CTRL, 32'h0);
        procLocked <= 0;
        wt(3);
        ck({ioComm, appRun}, 2'h0);
        ck(lHl, mss_pkg::LED_RED);
        rd(mss_pkg::ADDR_STATUS, 32'h2f);
        ioLocked <= 0;
        wt(3);
        ck({lIoH, lIoRdy, lIoRun}, {mss_pkg::LED_GREEN, mss_pkg::LED_OFF, mss_pkg::LED_RED});
        ck(chanOut, 16'h0);
        // fw fail, button, remote reset, critical fault; late causes wait for run
        for (int k = 0; k < 4; k++) begin
            procLocked <= 1;
            ioLocked <= 1;
            ioType <= 4'h5;
            do_reset();
            button <= (k == 1);
            if (k % 3 == 0) begin
                wt(20);
            end
            if (k != 1) begin
                wb(1, mss_pkg::ADDR_CTRL, (k == 0) ? 32'h2 : (k == 2) ? 32'h8 : 32'h1);
            end
            wt(30);
            button <= 0;
            ck({lRdy, lRun, lFrc, lSpr, lSys, lHl}, 12'hff5);
            ck({ioComm, appRun}, 2'h0);
        end
        wb(1, mss_pkg::ADDR_CTRL, 32'h5);
        wt(3);
        ck({lSys, lHl}, {mss_pkg::LED_RED, mss_pkg::LED_RED});
        wt(3);
        tally_and_finish();
    end
endmodule
